// File: logic/ims_pkg.sv
package ims_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 4;
    localparam int FLUSH_PULSE_NS = 250;
    localparam int WAKE_PULSE_MS  = 20;
    // least time, rounded up
    localparam int FLUSH_CYCLES   = (FLUSH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES    = WAKE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [6:0] CFG_TIMEOUT = 7'h40;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_BITMODE = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_PAD     = 8'h0C;
    localparam int CTRL_FSR_BIT = 0;

    // ---------------------------------------------------------------
    // configuration word layout
    // ---------------------------------------------------------------
    localparam logic [7:0]  CFG_WORD_ADDR = 8'h00;
    localparam logic [15:0] CFG_BLANK     = 16'hFFFF;
    localparam int CFG_MODE_LSB     = 0;
    localparam int CFG_MODE_W       = 3;
    localparam int CFG_DRIVE_LSB    = 3;
    localparam int CFG_SLEW_BIT     = 5;
    localparam int CFG_SCHMITT_BIT  = 6;
    localparam int CFG_PULLDOWN_BIT = 7;
    localparam logic [2:0] CFG_UART        = 3'h0;
    localparam logic [2:0] CFG_ASYNC_FIFO  = 3'h1;
    localparam logic [2:0] CFG_CPU_FIFO    = 3'h2;
    localparam logic [2:0] CFG_HALF_DUPLEX = 3'h3;
    localparam logic [2:0] CFG_FAST_SERIAL = 3'h4;
    localparam logic [1:0] DRIVE_DEFAULT   = 2'h0;

    // ---------------------------------------------------------------
    // host bit-mode command values
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_RESET      = 8'h00;
    localparam logic [7:0] CMD_ASYNC_BB   = 8'h01;
    localparam logic [7:0] CMD_ENGINE     = 8'h02;
    localparam logic [7:0] CMD_SYNC_BB    = 8'h04;
    localparam logic [7:0] CMD_SYNC_FIFO  = 8'h40;

    typedef enum logic [3:0] {
        MODE_UART, MODE_ASYNC_FIFO, MODE_SYNC_FIFO, MODE_CPU_FIFO,
        MODE_HALF_DUPLEX, MODE_FAST_SERIAL, MODE_ASYNC_BITBANG,
        MODE_SYNC_BITBANG, MODE_SERIAL_ENGINE
    } mode_t;

    // stored mode field to operating mode; blank or unknown gives uart
    function automatic mode_t cfgMode(input logic [15:0] w);
        mode_t m;
        m = MODE_UART;
        if (w != CFG_BLANK)
        begin
            case (w[CFG_MODE_LSB +: CFG_MODE_W])
                CFG_ASYNC_FIFO:  m = MODE_ASYNC_FIFO;
                CFG_CPU_FIFO:    m = MODE_CPU_FIFO;
                CFG_HALF_DUPLEX: m = MODE_HALF_DUPLEX;
                CFG_FAST_SERIAL: m = MODE_FAST_SERIAL;
                default:         m = MODE_UART;
            endcase
        end
        return m;
    endfunction

endpackage

// File: logic/interface_mode_selector.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// How it works
// - uart is the mode whenever nothing else was chosen
// - after reset the config word is read and its mode applied
// - stored modes: uart, async fifo, cpu fifo, half-duplex, fast serial
// - host command picks async bitbang, sync bitbang or serial engine
// - command 0x40 in parallel fifo mode selects synchronous fifo
// - synchronous fifo only when the stored mode is parallel fifo
// - pad drive, slew and schmitt come from the config word
// - host may reset fast serial controller; mode only from config
// - pull-down option blocks wake from the send/wake pin
// - in uart mode the ring indicator is the wake input
module interface_mode_selector
    import ims_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdData,
    input  wire logic        cfgPresent,
    output logic             cfgRead,
    output logic      [7:0]  cfgAddr,
    input  wire logic [15:0] cfgData,
    input  wire logic        cfgDataValid,
    input  wire logic        usbConfigured,
    input  wire logic        usbSuspended,
    input  wire logic        send_now_wake_n,
    input  wire logic        ring_indicate_n,
    output logic      [3:0]  modeSel,
    output logic             modeReady,
    output logic      [1:0]  padDrive,
    output logic             padSlowSlew,
    output logic             padSchmitt,
    output logic             fastSerialReset,
    output logic             sendImmediate,
    output logic             remoteWake
);
    initial
    begin
        if (WAKE_CNT <= FLUSH_CYCLES)
            $error("WAKE_CNT too small");
    end

    typedef enum {LD_START, LD_REQ, LD_WAIT, LD_DONE} load_t;

    load_t       ld_q;
    logic [6:0]  tmo_q;
    logic        loaded_q;
    logic        fallback_q;
    logic        refused_q;
    mode_t       mode_q;
    mode_t       base_q;
    logic [7:0]  lastCmd_q;
    logic [1:0]  drive_q;
    logic        slew_q;
    logic        schmitt_q;
    logic        pullDown_q;
    logic        fsr_q;
    logic        flush_q;
    logic        wake_q;
    logic        ringPrev_q;
    logic [31:0] rd_q;

    // ---------------------------------------------------------------
    // config word decode
    // ---------------------------------------------------------------
    wire   blank    = (cfgData == CFG_BLANK);
    wire   gotWord  = (ld_q == LD_WAIT) && cfgDataValid;
    wire   timedOut = (ld_q == LD_WAIT) && !cfgDataValid && (tmo_q == CFG_TIMEOUT);
    wire   noMemory = (ld_q == LD_START) && !cfgPresent;
    mode_t wordMode;
    assign wordMode = cfgMode(cfgData);

    // ---------------------------------------------------------------
    // host command decode
    // ---------------------------------------------------------------
    wire [7:0] cmdValue = regWrData[7:0];
    wire cmdWrite   = regWrite && (regAddr == ADDR_BITMODE);
    wire ctrlWrite  = regWrite && (regAddr == ADDR_CONTROL);
    wire hostReady  = loaded_q && usbConfigured;
    wire cmdSyncOk  = (base_q == MODE_ASYNC_FIFO);
    wire cmdKnown   = (cmdValue == CMD_RESET) || (cmdValue == CMD_ASYNC_BB)
                   || (cmdValue == CMD_SYNC_BB) || (cmdValue == CMD_ENGINE)
                   || ((cmdValue == CMD_SYNC_FIFO) && cmdSyncOk);
    wire cmdAccept  = cmdWrite && hostReady && cmdKnown;
    mode_t cmdTarget;
    // the reset command returns to whatever the config word chose
    assign cmdTarget = (cmdValue == CMD_ASYNC_BB)  ? MODE_ASYNC_BITBANG :
                       (cmdValue == CMD_SYNC_BB)   ? MODE_SYNC_BITBANG  :
                       (cmdValue == CMD_ENGINE)    ? MODE_SERIAL_ENGINE :
                       (cmdValue == CMD_SYNC_FIFO) ? MODE_SYNC_FIFO     :
                       base_q;
    // fast serial can be reset by the host but never selected by it
    wire fsrReq = ctrlWrite && regWrData[CTRL_FSR_BIT] && hostReady
               && (mode_q == MODE_FAST_SERIAL);

    // ---------------------------------------------------------------
    // loader state machine
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ld_q  <= LD_START;
            tmo_q <= '0;
        end
        else
        begin
            case (ld_q)
                LD_START: ld_q <= cfgPresent ? LD_REQ : LD_DONE;
                LD_REQ:   ld_q <= LD_WAIT;
                LD_WAIT:
                begin
                    tmo_q <= tmo_q + 7'h01;
                    if (gotWord || timedOut)
                        ld_q <= LD_DONE;
                end
                LD_DONE:  ld_q <= LD_DONE;
                default:  ld_q <= LD_START;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // mode and pad state
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            loaded_q   <= 1'b0;
            fallback_q <= 1'b0;
            mode_q     <= MODE_UART;
            base_q     <= MODE_UART;
            drive_q    <= DRIVE_DEFAULT;
            slew_q     <= 1'b0;
            schmitt_q  <= 1'b0;
            pullDown_q <= 1'b0;
        end
        else if (gotWord)
        begin
            loaded_q   <= 1'b1;
            fallback_q <= blank;
            mode_q     <= wordMode;
            base_q     <= wordMode;
            drive_q    <= blank ? DRIVE_DEFAULT
                                : cfgData[CFG_DRIVE_LSB +: 2];
            slew_q     <= !blank && cfgData[CFG_SLEW_BIT];
            schmitt_q  <= !blank && cfgData[CFG_SCHMITT_BIT];
            pullDown_q <= !blank && cfgData[CFG_PULLDOWN_BIT];
        end
        else if (timedOut || noMemory)
        begin
            loaded_q   <= 1'b1; // defaults already in place from reset
            fallback_q <= 1'b1;
        end
        else if (cmdAccept)
            mode_q <= cmdTarget;
    end

    // ---------------------------------------------------------------
    // register read selection
    // ---------------------------------------------------------------
    wire [31:0] rdMux =
        (regAddr == ADDR_STATUS)  ? {25'h0, refused_q, fallback_q, loaded_q, mode_q} :
        (regAddr == ADDR_BITMODE) ? {24'h0, lastCmd_q} :
        (regAddr == ADDR_PAD)     ? {27'h0, pullDown_q, schmitt_q, slew_q, drive_q} :
        32'h0;

    // ---------------------------------------------------------------
    // command bookkeeping, pulses and read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            refused_q  <= 1'b0;
            lastCmd_q  <= CMD_RESET;
            fsr_q      <= 1'b0;
            rd_q       <= '0;
        end
        else
        begin
            if (cmdWrite)
            begin
                refused_q <= !cmdAccept;
                lastCmd_q <= cmdValue;
            end
            fsr_q <= fsrReq;
            rd_q  <= regRead ? rdMux : '0;
        end
    end

    // ---------------------------------------------------------------
    // wake and flush from the pins
    // ---------------------------------------------------------------
    // the send/wake pin only serves fifo and bitbang modes
    wire pinActive = loaded_q && (mode_q != MODE_UART) && (mode_q != MODE_FAST_SERIAL)
                  && (mode_q != MODE_HALF_DUPLEX) && (mode_q != MODE_SERIAL_ENGINE);
    wire pinFlush;
    wire pinWake;
    wire ringFall  = ringPrev_q && !ring_indicate_n;
    wire isUart    = (mode_q == MODE_UART);
    wire wakeCause = isUart ? ringFall
                            : (pinWake && !pullDown_q);

    wake_pulse_classifier #(
        .WAKE_CNT (WAKE_CNT)
    ) u_classify (
        .clk        (clk),
        .rst_b      (rst_b),
        .pinLow     (pinActive && !send_now_wake_n),
        .flushPulse (pinFlush),
        .wakePulse  (pinWake)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ringPrev_q <= 1'b1;
            flush_q    <= 1'b0;
            wake_q     <= 1'b0;
        end
        else
        begin
            ringPrev_q <= ring_indicate_n;
            flush_q    <= pinFlush && !usbSuspended;
            wake_q     <= usbSuspended && loaded_q && wakeCause;
        end
    end

    assign regRdData       = rd_q;
    assign cfgRead         = (ld_q == LD_REQ);
    assign cfgAddr         = CFG_WORD_ADDR;
    assign modeSel         = mode_q;
    assign modeReady       = loaded_q;
    assign padDrive        = drive_q;
    assign padSlowSlew     = slew_q;
    assign padSchmitt      = schmitt_q;
    assign fastSerialReset = fsr_q;
    assign sendImmediate   = flush_q;
    assign remoteWake      = wake_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_fallback_uart;
        @(posedge clk) disable iff (!rst_b)
        $rose(loaded_q) && fallback_q |-> mode_q == MODE_UART && drive_q == DRIVE_DEFAULT
                                         && !slew_q && !schmitt_q;
    endproperty
    a_fallback_uart: assert property (p_fallback_uart)
        else $error("fallback did not give uart with default pads");

    property p_load_word;
        @(posedge clk) disable iff (!rst_b)
        gotWord |=> loaded_q && mode_q == $past(wordMode) && base_q == mode_q;
    endproperty
    a_load_word: assert property (p_load_word)
        else $error("config word not applied");

    property p_stored_set;
        @(posedge clk) disable iff (!rst_b)
        $rose(loaded_q) |-> mode_q inside {MODE_UART, MODE_ASYNC_FIFO, MODE_CPU_FIFO,
                                           MODE_HALF_DUPLEX, MODE_FAST_SERIAL};
    endproperty
    a_stored_set: assert property (p_stored_set)
        else $error("config produced a host-only mode");

    property p_sync_cmd;
        @(posedge clk) disable iff (!rst_b)
        cmdWrite && hostReady && cmdValue == CMD_SYNC_FIFO && base_q == MODE_ASYNC_FIFO
        |=> mode_q == MODE_SYNC_FIFO ##1 mode_q == MODE_SYNC_FIFO || $past(cmdAccept);
    endproperty
    a_sync_cmd: assert property (p_sync_cmd)
        else $error("sync fifo command not taken");

    property p_sync_needs_cfg;
        @(posedge clk) disable iff (!rst_b)
        mode_q == MODE_SYNC_FIFO |-> base_q == MODE_ASYNC_FIFO;
    endproperty
    a_sync_needs_cfg: assert property (p_sync_needs_cfg)
        else $error("sync fifo without stored parallel fifo");

    property p_pads_hold;
        @(posedge clk) disable iff (!rst_b)
        loaded_q |=> $stable(drive_q) && $stable(slew_q) && $stable(schmitt_q);
    endproperty
    a_pads_hold: assert property (p_pads_hold)
        else $error("pad settings changed after load");

    property p_fsr;
        @(posedge clk) disable iff (!rst_b)
        fastSerialReset |-> mode_q == MODE_FAST_SERIAL && base_q == MODE_FAST_SERIAL;
    endproperty
    a_fsr: assert property (p_fsr)
        else $error("fast serial reset outside fast serial mode");

    property p_wake_src;
        @(posedge clk) disable iff (!rst_b)
        remoteWake |-> $past(usbSuspended) && ($past(isUart) ? $past(ringFall)
                                             : ($past(pinWake) && !$past(pullDown_q)));
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("wake from a blocked or wrong source");

    property p_mode_stable;
        @(posedge clk) disable iff (!rst_b)
        loaded_q && !cmdAccept |=> $stable(mode_q);
    endproperty
    a_mode_stable: assert property (p_mode_stable)
        else $error("mode changed without a command");

endmodule // interface_mode_selector

// File: logic/wake_pulse_classifier.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// measures low pulses on the wake pin: ones of at least FLUSH_CYCLES flush, long wake
// ---------------------------------------------------------------
module wake_pulse_classifier
    import ims_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_CYCLES,
    parameter int CNT_W    = 23
)
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pinLow,
    output logic      flushPulse,
    output logic      wakePulse
);
    initial
    begin
        if (WAKE_CNT <= FLUSH_CYCLES || WAKE_CNT >= (1 << CNT_W))
            $error("wake count must exceed flush count and fit CNT_W");
    end

    logic [CNT_W-1:0] lowCnt_q;
    logic             woke_q;
    logic             flush_q;
    logic             wake_q;

    // counter saturates so a held pin cannot wrap into a false flush
    wire atWake  = (lowCnt_q == CNT_W'(WAKE_CNT - 1));
    wire longLow = (lowCnt_q >= CNT_W'(FLUSH_CYCLES));

    // ---------------------------------------------------------------
    // pulse measurement
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            lowCnt_q <= '0;
            woke_q   <= 1'b0;
            flush_q  <= 1'b0;
            wake_q   <= 1'b0;
        end
        else
        begin
            flush_q <= !pinLow && longLow && !woke_q;
            wake_q  <= pinLow && atWake && !woke_q;
            if (pinLow && atWake)
                woke_q <= 1'b1;
            else if (!pinLow)
                woke_q <= 1'b0;
            if (!pinLow)
                lowCnt_q <= '0;
            else if (!atWake)
                lowCnt_q <= lowCnt_q + 1'b1;
        end
    end

    assign flushPulse = flush_q;
    assign wakePulse  = wake_q;

    property p_flush_len;
        @(posedge clk) disable iff (!rst_b)
        flush_q |-> $past(longLow, 1) && !$past(pinLow, 1);
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush without a long enough low pulse");

endmodule // wake_pulse_classifier

// File: tb/cfg_memory_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// configuration memory: answers one word read after a set lag
// ---------------------------------------------------------------
module cfg_memory_model
(
    input  wire logic        clk,
    input  wire logic        cfgRead,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [15:0] word,
    input  wire logic [7:0]  lag,
    output logic      [15:0] cfgData,
    output logic             cfgDataValid
);
    logic        busy;
    logic [7:0]  waitCnt;
    logic [7:0]  addrHeld;
    logic [15:0] lastData;

    // power-up: idle bus with an arbitrary pattern
    initial
    begin
        busy = 1'b0;
        waitCnt = 8'h00;
        addrHeld = 8'h00;
        lastData = 16'h5A5A;
        cfgData = 16'hA5A5;
        cfgDataValid = 1'b0;
    end

    // released bus shows the inverse of the last word, so a late sample never
    // sees a stale copy; only word 0 holds data, other words read blank
    always @(posedge clk)
    begin
        cfgDataValid <= 1'b0;
        cfgData      <= ~lastData;
        if (cfgRead && !busy)
        begin
            busy     <= 1'b1;
            waitCnt  <= lag;
            addrHeld <= cfgAddr;
        end
        else if (busy && waitCnt != 8'h00)
            waitCnt <= waitCnt - 8'h01;
        else if (busy)
        begin
            busy         <= 1'b0;
            cfgDataValid <= 1'b1;
            cfgData      <= (addrHeld == 8'h00) ? word : 16'hFFFF;
            lastData     <= (addrHeld == 8'h00) ? word : 16'hFFFF;
        end
    end
endmodule // cfg_memory_model

// File: tb/tb.sv
`timescale 1ns/10ps
module tb
    import ims_pkg::*;
;
    localparam int WAKE_T = 200;
    logic        clk, rst_b, regWrite, regRead, cfgPresent, cfgRead, cfgDataValid;
    logic        usbConfigured, usbSuspended, send_now_wake_n, ring_indicate_n;
    logic        modeReady, padSlowSlew, padSchmitt, fastSerialReset;
    logic        sendImmediate, remoteWake;
    logic [7:0]  regAddr, cfgAddr, cfgLag;
    logic [31:0] regWrData, regRdData;
    logic [15:0] cfgData, cfgWord;
    logic [3:0]  modeSel;
    logic [1:0]  padDrive;
    int          errors, nChecks, nFlush, nWake, nFsr;

    // wake count shortened so a long pulse fits the run
    interface_mode_selector #(.WAKE_CNT(WAKE_T)) dut
    (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .cfgPresent(cfgPresent), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
        .cfgData(cfgData), .cfgDataValid(cfgDataValid), .usbConfigured(usbConfigured),
        .usbSuspended(usbSuspended), .send_now_wake_n(send_now_wake_n),
        .ring_indicate_n(ring_indicate_n), .modeSel(modeSel), .modeReady(modeReady),
        .padDrive(padDrive), .padSlowSlew(padSlowSlew), .padSchmitt(padSchmitt),
        .fastSerialReset(fastSerialReset), .sendImmediate(sendImmediate),
        .remoteWake(remoteWake)
    );

    cfg_memory_model mem
    (
        .clk(clk), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .word(cfgWord),
        .lag(cfgLag), .cfgData(cfgData), .cfgDataValid(cfgDataValid)
    );

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulse counters; windows are judged on differences
    always @(posedge clk)
    begin
        if (sendImmediate === 1'b1)
            nFlush <= nFlush + 1;
        if (remoteWake === 1'b1)
            nWake <= nWake + 1;
        if (fastSerialReset === 1'b1)
            nFsr <= nFsr + 1;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite  <= 1'b0;
        @(posedge clk);
    endtask

    // sampled at the edge after the answer cycle opens, before it updates
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        d = regRdData;
    endtask

    task automatic boot(input logic pres, input logic [15:0] w, input logic [7:0] lg);
        int i;
        rst_b      <= 1'b0;
        cfgPresent <= pres;
        cfgWord    <= w;
        cfgLag     <= lg;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        i = 0;
        while (modeReady !== 1'b1 && i < 200)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 200)
        begin
            errors++;
            $display("BAD t=%0t load never finished", $time);
            complete_run();
        end
    endtask

    task automatic mode_is(input mode_t m, input logic refusedExp);
        logic [31:0] r;
        rd(ADDR_STATUS, r);
        chk(32'(modeSel), 32'(m));
        chk(32'(r[3:0]), 32'(m));
        chk(32'(r[6]), 32'(refusedExp));
    endtask

    // low of n cycles on either pin; flush and wake pulses counted afterwards
    task automatic pulse_low(input logic ring, input int n, input int ef, input int ew);
        int f;
        int w;
        f = nFlush;
        w = nWake;
        @(posedge clk);
        if (ring)
            ring_indicate_n <= 1'b0;
        else
            send_now_wake_n <= 1'b0;
        repeat (n) @(posedge clk);
        ring_indicate_n <= 1'b1;
        send_now_wake_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(nFlush - f), 32'(ef));
        chk(32'(nWake - w), 32'(ew));
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic s_default();
        logic [31:0] r;
        boot(1'b1, CFG_BLANK, 8'h03);
        chk(32'(modeSel), 32'(MODE_UART));
        chk(32'({padSchmitt, padSlowSlew, padDrive}), 32'(DRIVE_DEFAULT));
        boot(1'b0, 16'h0001, 8'h03);
        chk(32'(modeSel), 32'(MODE_UART));
        rd(ADDR_STATUS, r);
        chk(32'(r[5]), 32'h1);
    endtask

    task automatic s_modes();
        logic [31:0] r;
        logic [15:0] w;
        logic [2:0]  k;
        mode_t       exp [6] = '{MODE_UART, MODE_ASYNC_FIFO, MODE_CPU_FIFO,
                                 MODE_HALF_DUPLEX, MODE_FAST_SERIAL, MODE_UART};
        for (int i = 0; i < 6; i++)
        begin
            k = 3'(i);
            w = {8'h00, k[1], ~k[0], k[0], k[1:0], (i < 5) ? k : 3'h7};
            boot(1'b1, w, 8'(i * 4));
            chk(32'(modeSel), 32'(exp[i]));
            chk(32'({padSchmitt, padSlowSlew, padDrive}), 32'(w[6:3]));
            rd(ADDR_PAD, r);
            chk(r, 32'(w[7:3]));
        end
    endtask

    task automatic s_cmds();
        logic [7:0] cmd [6] = '{CMD_SYNC_FIFO, CMD_ASYNC_BB, CMD_ENGINE, CMD_SYNC_BB,
                                CMD_RESET, 8'h13};
        mode_t      exp [6] = '{MODE_SYNC_FIFO, MODE_ASYNC_BITBANG, MODE_SERIAL_ENGINE,
                                MODE_SYNC_BITBANG, MODE_ASYNC_FIFO, MODE_ASYNC_FIFO};
        logic [31:0] r;
        boot(1'b1, 16'(CFG_ASYNC_FIFO), 8'h02);
        usbConfigured <= 1'b0;
        wr(ADDR_BITMODE, 32'(CMD_ASYNC_BB));
        mode_is(MODE_ASYNC_FIFO, 1'b1);
        usbConfigured <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_BITMODE, 32'(cmd[i]));
            mode_is(exp[i], i == 5);
        end
        rd(ADDR_BITMODE, r);
        chk(r, 32'(cmd[5]));
        repeat (30) @(posedge clk);
        mode_is(MODE_ASYNC_FIFO, 1'b1);
    endtask

    task automatic s_guard();
        boot(1'b1, 16'(CFG_CPU_FIFO), 8'h02);
        wr(ADDR_BITMODE, 32'(CMD_SYNC_FIFO));
        mode_is(MODE_CPU_FIFO, 1'b1);
        boot(1'b1, 16'(CFG_UART), 8'h02);
        wr(ADDR_BITMODE, 32'(CMD_SYNC_FIFO));
        mode_is(MODE_UART, 1'b1);
    endtask

    task automatic s_fast();
        int n;
        boot(1'b1, 16'(CFG_FAST_SERIAL), 8'h05);
        n = nFsr;
        wr(ADDR_CONTROL, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(nFsr - n), 32'h1);
        wr(ADDR_BITMODE, 32'(CMD_ENGINE));
        wr(ADDR_BITMODE, 32'(CMD_RESET));
        mode_is(MODE_FAST_SERIAL, 1'b0);
        boot(1'b1, 16'(CFG_UART), 8'h05);
        n = nFsr;
        wr(ADDR_CONTROL, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(nFsr - n), 32'h0);
    endtask

    // 70 cycles is above the flush minimum; WAKE_T + 10 passes the wake length
    task automatic s_wake();
        logic [31:0] r;
        boot(1'b1, 16'(CFG_ASYNC_FIFO), 8'h02);
        usbSuspended <= 1'b0;
        pulse_low(1'b0, 70, 1, 0);
        usbSuspended <= 1'b1;
        pulse_low(1'b0, WAKE_T + 10, 0, 1);
        boot(1'b1, 16'h0081, 8'h02);
        pulse_low(1'b0, WAKE_T + 10, 0, 0);
        boot(1'b1, 16'(CFG_UART), 8'h02);
        pulse_low(1'b0, WAKE_T + 10, 0, 0);
        pulse_low(1'b1, 8, 0, 1);
        // memory too slow to answer: the load times out and falls back to uart
        boot(1'b1, 16'(CFG_ASYNC_FIFO), 8'hC8);
        chk(32'(modeSel), 32'(MODE_UART));
        rd(ADDR_STATUS, r);
        chk(32'(r[5:4]), 32'h3);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        cfgPresent = 1'b1;
        cfgWord = CFG_BLANK;
        cfgLag = 8'h02;
        usbConfigured = 1'b1;
        usbSuspended = 1'b0;
        send_now_wake_n = 1'b1;
        ring_indicate_n = 1'b1;
        errors = 0;
        nChecks = 0;
        nFlush = 0;
        nWake = 0;
        nFsr = 0;
        s_default();
        s_modes();
        s_cmds();
        s_guard();
        s_fast();
        s_wake();
        complete_run();
    end
endmodule // tb
